// file: sfep_consts.vh
`ifndef SFEP_CONSTS_VH
`define SFEP_CONSTS_VH

// Command opcodes
`define SFEP_OP_WR_ENABLE   8'h06
`define SFEP_OP_BLOCK_ERASE 8'hd8
`define SFEP_OP_CHIP_ERASE  8'hc7
`define SFEP_OP_CHIP_ERASE2 8'h60
`define SFEP_OP_PAGE_PROG   8'h02
`define SFEP_OP_DUAL_PROG   8'ha2
`define SFEP_OP_QUAD_PROG   8'h32

// Field layout
`define SFEP_ADDR_W         24
`define SFEP_ADDR_BYTES     2'h2
`define SFEP_PAGE_LSB       8
`define SFEP_BLOCK_LSB      16
`define SFEP_BLOCK_MSB      18
`define SFEP_BP_W           5
`define SFEP_BP_NONE        5'h00
`define SFEP_BLOCKS         4'h8

// Self-timed cycle lengths, clock in MHz
`define SFEP_CLK_MHZ               200
`define SFEP_BLOCK_ERASE_TIME_MS   500
`define SFEP_CHIP_ERASE_TIME_MS    3000
`define SFEP_PAGE_PROGRAM_TIME_US  2000
`define SFEP_BLOCK_ERASE_CYCLES    (`SFEP_BLOCK_ERASE_TIME_MS * 1000 * `SFEP_CLK_MHZ)
`define SFEP_CHIP_ERASE_CYCLES     (`SFEP_CHIP_ERASE_TIME_MS * 1000 * `SFEP_CLK_MHZ)
`define SFEP_PAGE_PROGRAM_CYCLES   (`SFEP_PAGE_PROGRAM_TIME_US * `SFEP_CLK_MHZ)

`endif

// file: sfep_core.v
//Contract
// [R1] Block erase clears the whole addressed 64 KB block; any address inside works.
// [R2] Block erase is opcode D8 plus three address bytes on line 0 only.
// [R3] Erase or program runs only with the write enable latch set.
// [R4] Block erase select must rise right after the last address bit, else rejected.
// [R5] Accepted command starts timed cycle; busy flag high, then cleared with latch.
// [R6] A block covered by the protect bits is not erased.
// [R7] Chip erase is opcode only, select rising at its boundary, erases everything.
// [R8] Chip erase runs only when the protect bits protect nothing.
// [R9] Program only clears bits and keeps just the last 256 bytes sent.
// [R10] Data past the page end wraps to the page start.
// [R11] Short data goes from the start address; other page bytes untouched.
// [R12] Program is opcode, address, one or more data bytes, select rises on boundary.
// [R13] Program on a protected page is not executed.
// [R14] Host should program whole aligned pages once for best time.
// [R15] Dual program uses opcode A2, address on line 0, data on lines 0 and 1.
// [R16] Dual program takes 1 to 256 bytes, else like single-line program.
// [R17] Quad program uses opcode 32, address on line 0, data on lines 0 to 3.
// [R18] Quad program needs quad enable set as well as the latch.
// [R19] Bits arrive MSB first on rising clock; highest line holds the MSB.
// [R20] Rejected commands leave the busy flag low; commands ignored while busy.
`timescale 1ns/1ps
`include "sfep_consts.vh"
module sfep_core #(
  parameter [31:0] BLOCK_ERASE_CYCLES = `SFEP_BLOCK_ERASE_CYCLES,
  parameter [31:0] CHIP_ERASE_CYCLES  = `SFEP_CHIP_ERASE_CYCLES,
  parameter [31:0] PAGE_PROG_CYCLES   = `SFEP_PAGE_PROGRAM_CYCLES
) (
  // Clocking
  input  wire                     clk_i,
  input  wire                     reset_i,
  input  wire                     ce_i,
  // Serial link pins
  input  wire                     chip_select_n_i,
  input  wire                     serial_clock_i,
  input  wire                     io_line_0_i,
  input  wire                     io_line_1_i,
  input  wire                     io_line_2_i,
  input  wire                     io_line_3_i,
  // Configuration
  input  wire [`SFEP_BP_W-1:0]    block_protect_bits_i,
  input  wire                     quad_enable_i,
  // Status
  output reg                      write_in_progress_o,
  output reg                      write_enable_latch_o,
  output reg                      cmd_reject_o,
  // Array operations
  output reg                      erase_block_o,
  output reg                      erase_chip_o,
  output reg  [`SFEP_ADDR_W-1:0]  erase_addr_o,
  output reg                      prog_we_o,
  output reg  [`SFEP_ADDR_W-1:0]  prog_addr_o,
  output reg  [7:0]               prog_data_o
);
  localparam [5:0] L_IDLE = 6'b000001;
  localparam [5:0] L_OPC  = 6'b000010;
  localparam [5:0] L_ADDR = 6'b000100;
  localparam [5:0] L_DATA = 6'b001000;
  localparam [5:0] L_TAIL = 6'b010000;
  localparam [5:0] L_SKIP = 6'b100000;

  localparam [2:0] X_IDLE  = 3'b001;
  localparam [2:0] X_FLUSH = 3'b010;
  localparam [2:0] X_TIME  = 3'b100;

  localparam [31:0] BLK_LOAD  = BLOCK_ERASE_CYCLES - 32'h1;
  localparam [31:0] CE_LOAD   = CHIP_ERASE_CYCLES - 32'h1;
  localparam [31:0] PROG_LOAD = PAGE_PROG_CYCLES - 32'h1;

  // Protect decode: bp[4] all, bp[2:0] block count, bp[3] bottom side
  function is_protected;
    input [2:0]            blk;
    input [`SFEP_BP_W-1:0] bp;
    reg   [3:0]            n;
    begin
      n = 4'h0;
      if (bp[2:0] >= 3'h4) begin
        n = `SFEP_BLOCKS;
      end else if (bp[2:0] != 3'h0) begin
        n = 4'h1 << (bp[2:0] - 3'h1);
      end
      if (bp[4]) begin
        is_protected = 1'b1;
      end else if (bp[3]) begin
        is_protected = ({1'b0, blk} < n);
      end else begin
        is_protected = ({1'b0, blk} >= (`SFEP_BLOCKS - n));
      end
    end
  endfunction

  // Shift w bits in, highest line as MSB
  function [7:0] shift_in;
    input [7:0] sr;
    input [3:0] io;
    input [2:0] w;
    begin
      case (w)
        3'h2:    shift_in = {sr[5:0], io[1:0]};
        3'h4:    shift_in = {sr[3:0], io[3:0]};
        default: shift_in = {sr[6:0], io[0]};
      endcase
    end
  endfunction

  wire [5:0] pins_s;
  reg        sclk_d;
  reg        cs_d;

  sfep_sync #(.WIDTH(6)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .async_i ({serial_clock_i, chip_select_n_i,
               io_line_3_i, io_line_2_i, io_line_1_i, io_line_0_i}),
    .sync_o  (pins_s)
  );

  wire       sclk_rise = pins_s[5] & ~sclk_d;
  wire       cs_rise   = pins_s[4] & ~cs_d;
  wire       cs_fall   = ~pins_s[4] & cs_d;
  wire [3:0] io_s      = pins_s[3:0];

  reg  [5:0]              lstate;
  reg  [2:0]              xstate;
  reg  [7:0]              opcode;
  reg  [7:0]              sr;
  reg  [2:0]              bit_cnt;
  reg  [2:0]              dwidth;
  reg  [1:0]              byte_cnt;
  reg  [`SFEP_ADDR_W-1:0] addr;
  reg  [7:0]              data_off;
  reg                     data_seen;
  reg                     overrun;
  reg                     frame_busy;
  reg  [31:0]             timer;
  reg  [7:0]              flush_idx;
  reg  [15:0]             page;
  reg                     buf_wr;
  reg  [7:0]              buf_idx;
  reg  [7:0]              buf_data;
  reg                     buf_clr;
  wire [7:0]              rd_data;
  wire                    rd_valid;

  wire [2:0] w_now    = (lstate == L_DATA) ? dwidth : 3'h1;
  wire [3:0] bit_sum  = {1'b0, bit_cnt} + {1'b0, w_now};
  wire [7:0] sr_next  = shift_in(sr, io_s, w_now); // [R19]
  wire       byte_end = bit_sum[3];
  wire       is_prog  = (opcode == `SFEP_OP_PAGE_PROG) || (opcode == `SFEP_OP_DUAL_PROG) ||
                        (opcode == `SFEP_OP_QUAD_PROG);
  wire       idle_ok  = (xstate == X_IDLE) && !frame_busy; // [R20]
  wire       tail_ok  = (lstate == L_TAIL) && !overrun && (bit_cnt == 3'h0);
  wire       data_ok  = (lstate == L_DATA) && data_seen && (bit_cnt == 3'h0);

  sfep_page_buf u_buf (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .clr_i      (buf_clr),
    .wr_i       (buf_wr),
    .wr_idx_i   (buf_idx),
    .wr_data_i  (buf_data),
    .rd_idx_i   (flush_idx),
    .rd_data_o  (rd_data),
    .rd_valid_o (rd_valid)
  );

  always @(posedge clk_i) begin
    if (reset_i) begin
      sclk_d               <= 1'b1;
      cs_d                 <= 1'b1;
      lstate               <= L_IDLE;
      xstate               <= X_IDLE;
      opcode               <= 8'h00;
      sr                   <= 8'h00;
      bit_cnt              <= 3'h0;
      dwidth               <= 3'h1;
      byte_cnt             <= 2'h0;
      addr                 <= 24'h000000;
      data_off             <= 8'h00;
      data_seen            <= 1'b0;
      overrun              <= 1'b0;
      frame_busy           <= 1'b0;
      timer                <= 32'h00000000;
      flush_idx            <= 8'h00;
      page                 <= 16'h0000;
      buf_wr               <= 1'b0;
      buf_idx              <= 8'h00;
      buf_data             <= 8'h00;
      buf_clr              <= 1'b0;
      write_in_progress_o  <= 1'b0;
      write_enable_latch_o <= 1'b0;
      cmd_reject_o         <= 1'b0;
      erase_block_o        <= 1'b0;
      erase_chip_o         <= 1'b0;
      erase_addr_o         <= 24'h000000;
      prog_we_o            <= 1'b0;
      prog_addr_o          <= 24'h000000;
      prog_data_o          <= 8'h00;
    end else if (ce_i) begin
      sclk_d        <= pins_s[5];
      cs_d          <= pins_s[4];
      buf_wr        <= 1'b0;
      buf_clr       <= 1'b0;
      cmd_reject_o  <= 1'b0;
      erase_block_o <= 1'b0;
      erase_chip_o  <= 1'b0;
      prog_we_o     <= 1'b0;

      // Link side: frame start, end and bit shifting
      if (cs_fall) begin
        lstate     <= L_OPC;
        sr         <= 8'h00;
        bit_cnt    <= 3'h0;
        byte_cnt   <= 2'h0;
        dwidth     <= 3'h1;
        data_off   <= 8'h00;
        data_seen  <= 1'b0;
        overrun    <= 1'b0;
        frame_busy <= (xstate != X_IDLE); // [R20]
        if (xstate == X_IDLE) begin
          buf_clr <= 1'b1;
        end
      end else if (cs_rise) begin
        lstate <= L_IDLE;
        if (tail_ok && idle_ok && (opcode == `SFEP_OP_WR_ENABLE)) begin
          write_enable_latch_o <= 1'b1;
        end else if (tail_ok && (opcode == `SFEP_OP_BLOCK_ERASE)) begin // [R4]
          if (!idle_ok || !write_enable_latch_o) begin // [R3]
            cmd_reject_o <= 1'b1;
          end else if (is_protected(addr[`SFEP_BLOCK_MSB:`SFEP_BLOCK_LSB],
                                    block_protect_bits_i)) begin // [R6]
            write_enable_latch_o <= 1'b0;
            cmd_reject_o         <= 1'b1;
          end else begin
            erase_block_o       <= 1'b1; // [R1]
            erase_addr_o        <= {addr[`SFEP_ADDR_W-1:`SFEP_BLOCK_LSB], 16'h0000};
            write_in_progress_o <= 1'b1; // [R5]
            timer               <= BLK_LOAD;
            xstate              <= X_TIME;
          end
        end else if (tail_ok && ((opcode == `SFEP_OP_CHIP_ERASE) ||
                                 (opcode == `SFEP_OP_CHIP_ERASE2))) begin // [R7]
          if (!idle_ok || !write_enable_latch_o) begin // [R3]
            cmd_reject_o <= 1'b1;
          end else if (block_protect_bits_i != `SFEP_BP_NONE) begin // [R8]
            write_enable_latch_o <= 1'b0;
            cmd_reject_o         <= 1'b1;
          end else begin
            erase_chip_o        <= 1'b1;
            erase_addr_o        <= 24'h000000;
            write_in_progress_o <= 1'b1; // [R5]
            timer               <= CE_LOAD;
            xstate              <= X_TIME;
          end
        end else if (data_ok && is_prog) begin // [R12]
          if (!idle_ok || !write_enable_latch_o) begin // [R3]
            cmd_reject_o <= 1'b1;
          end else if (is_protected(addr[`SFEP_BLOCK_MSB:`SFEP_BLOCK_LSB],
                                    block_protect_bits_i)) begin // [R13]
            write_enable_latch_o <= 1'b0;
            cmd_reject_o         <= 1'b1;
          end else begin
            page                <= addr[`SFEP_ADDR_W-1:`SFEP_PAGE_LSB];
            flush_idx           <= 8'h00;
            write_in_progress_o <= 1'b1; // [R5]
            xstate              <= X_FLUSH;
          end
        end else if (lstate != L_IDLE) begin
          cmd_reject_o <= 1'b1; // [R20]
        end
      end else if (sclk_rise && !pins_s[4]) begin
        case (lstate)
          L_OPC: begin
            sr      <= sr_next;
            bit_cnt <= bit_sum[2:0];
            if (byte_end) begin
              opcode <= sr_next;
              case (sr_next)
                `SFEP_OP_WR_ENABLE, `SFEP_OP_CHIP_ERASE, `SFEP_OP_CHIP_ERASE2: begin
                  lstate <= L_TAIL;
                end
                `SFEP_OP_BLOCK_ERASE, `SFEP_OP_PAGE_PROG: begin
                  lstate <= L_ADDR; // [R2]
                  dwidth <= 3'h1;
                end
                `SFEP_OP_DUAL_PROG: begin
                  lstate <= L_ADDR; // [R15]
                  dwidth <= 3'h2;
                end
                `SFEP_OP_QUAD_PROG: begin
                  lstate <= quad_enable_i ? L_ADDR : L_SKIP; // [R18]
                  dwidth <= 3'h4; // [R17]
                end
                default: begin
                  lstate <= L_SKIP;
                end
              endcase
            end
          end
          L_ADDR: begin
            sr      <= sr_next;
            bit_cnt <= bit_sum[2:0];
            if (byte_end) begin
              addr     <= {addr[15:0], sr_next};
              byte_cnt <= byte_cnt + 2'h1;
              if (byte_cnt == `SFEP_ADDR_BYTES) begin
                lstate <= is_prog ? L_DATA : L_TAIL;
              end
            end
          end
          L_DATA: begin
            sr      <= sr_next;
            bit_cnt <= bit_sum[2:0];
            if (byte_end) begin
              data_seen <= 1'b1;
              data_off  <= data_off + 8'h01;
              buf_wr    <= idle_ok;
              buf_idx   <= addr[7:0] + data_off; // [R10] [R11] [R16]
              buf_data  <= sr_next;
            end
          end
          L_TAIL: begin
            overrun <= 1'b1; // [R4] [R7]
          end
          default: begin
            lstate <= L_SKIP;
          end
        endcase
      end

      // Execution side: page flush then self-timed wait
      case (xstate)
        X_IDLE: begin
        end
        X_FLUSH: begin
          prog_we_o   <= rd_valid; // [R9] [R11]
          prog_addr_o <= {page, flush_idx};
          prog_data_o <= rd_data;
          flush_idx   <= flush_idx + 8'h01;
          if (flush_idx == 8'hff) begin
            buf_clr <= 1'b1;
            timer   <= PROG_LOAD;
            xstate  <= X_TIME;
          end
        end
        X_TIME: begin
          if (timer == 32'h00000000) begin
            write_in_progress_o  <= 1'b0; // [R5]
            write_enable_latch_o <= 1'b0;
            xstate               <= X_IDLE;
          end else begin
            timer <= timer - 32'h00000001;
          end
        end
        default: begin
          xstate <= X_IDLE;
        end
      endcase
    end
  end
endmodule

// file: sfep_core_sva.sv
`timescale 1ns/1ps
module sfep_core_sva #(
  parameter [31:0] BLOCK_ERASE_CYCLES = 32'h14,
  parameter [31:0] CHIP_ERASE_CYCLES  = 32'h1e,
  parameter [31:0] PAGE_PROG_CYCLES   = 32'ha
) (
  // Clocking
  input wire        clk_i,
  input wire        reset_i,
  // Status
  input wire        write_in_progress_o,
  input wire        write_enable_latch_o,
  input wire        cmd_reject_o,
  // Array operations
  input wire        erase_block_o,
  input wire        erase_chip_o,
  input wire [23:0] erase_addr_o,
  input wire        prog_we_o,
  input wire [23:0] prog_addr_o
);
  localparam int BEM = BLOCK_ERASE_CYCLES - 1;
  localparam int CEM = CHIP_ERASE_CYCLES - 1;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Busy level ends exactly after the timed cycle
  sequence s_blk_end;
    ##BEM write_in_progress_o ##1 !write_in_progress_o;
  endsequence
  sequence s_ce_end;
    ##CEM write_in_progress_o ##1 !write_in_progress_o;
  endsequence
  chk_busy_needs_latch: assert property (
    $rose(write_in_progress_o) |-> write_enable_latch_o)
    else $error("busy started without latch");
  chk_erase_starts_busy: assert property (
    (erase_block_o || erase_chip_o) |-> $rose(write_in_progress_o))
    else $error("erase without busy start");
  chk_block_base: assert property (
    erase_block_o |-> erase_addr_o[15:0] == 16'h0000)
    else $error("block erase address not block base");
  chk_chip_base: assert property (
    erase_chip_o |-> erase_addr_o == 24'h000000)
    else $error("chip erase address not zero");
  chk_blk_length: assert property (erase_block_o |-> s_blk_end)
    else $error("block erase busy length wrong");
  chk_ce_length: assert property (erase_chip_o |-> s_ce_end)
    else $error("chip erase busy length wrong");
  chk_end_clears_latch: assert property (
    $fell(write_in_progress_o) |-> !write_enable_latch_o)
    else $error("latch kept after cycle end");
  chk_reject_no_start: assert property (
    cmd_reject_o |-> !$rose(write_in_progress_o) ##1 !$rose(write_in_progress_o))
    else $error("rejected command started a cycle");
  chk_prog_in_cycle: assert property (
    prog_we_o |-> write_in_progress_o && write_enable_latch_o)
    else $error("program write outside cycle");
  chk_page_wrap: assert property (
    prog_we_o && $past(prog_we_o) |->
      prog_addr_o == {$past(prog_addr_o[23:8]), $past(prog_addr_o[7:0]) + 8'h01})
    else $error("program address left the page");
  chk_busy_min: assert property (
    $rose(write_in_progress_o) |-> write_in_progress_o[*8])
    else $error("busy flag too short");
endmodule

bind sfep_core sfep_core_sva #(
  .BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES),
  .CHIP_ERASE_CYCLES (CHIP_ERASE_CYCLES),
  .PAGE_PROG_CYCLES  (PAGE_PROG_CYCLES)
) u_sva (
  .clk_i               (clk_i),
  .reset_i             (reset_i),
  .write_in_progress_o (write_in_progress_o),
  .write_enable_latch_o(write_enable_latch_o),
  .cmd_reject_o        (cmd_reject_o),
  .erase_block_o       (erase_block_o),
  .erase_chip_o        (erase_chip_o),
  .erase_addr_o        (erase_addr_o),
  .prog_we_o           (prog_we_o),
  .prog_addr_o         (prog_addr_o)
);

// file: sfep_host.sv
`timescale 1ns/1ps
module sfep_host (
  // Link pins
  output logic       cs_n_o,
  output logic       sclk_o,
  output logic [3:0] io_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o   = 4'h0;
  end
  // One bit period, data set while the clock is low
  task automatic tick();
    #24 sclk_o = 1'b1;
    #24 sclk_o = 1'b0;
  endtask
  // Byte over w lines, MSB first, top line carries the MSB
  task automatic put(input logic [7:0] v, input int w);
    for (int b = 7; b >= 0; b -= w) begin
      io_o = ~io_o;
      for (int j = 0; j < w; j++)
        io_o[j] = v[b-w+1+j];
      tick();
    end
  endtask
  // Whole frame: opcode, address, data bytes, then xb stray bits
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na,
                       input int nd, input int w, input int xb, input logic [7:0] sd);
    cs_n_o = 1'b0;
    #24;
    put(op, 1);
    if (na != 0) begin
      put(a[23:16], 1);
      put(a[15:8], 1);
      put(a[7:0], 1);
    end
    for (int k = 0; k < nd; k++)
      put(k[8:1] ^ sd, w);
    for (int i = 0; i < xb; i++) begin
      io_o = ~io_o;
      tick();
    end
    #24 cs_n_o = 1'b1;
    io_o = ~io_o;
    #96;
  endtask
endmodule

// file: sfep_page_buf.v
`timescale 1ns/1ps
module sfep_page_buf (
  // Clocking
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       ce_i,
  // Write side
  input  wire       clr_i,
  input  wire       wr_i,
  input  wire [7:0] wr_idx_i,
  input  wire [7:0] wr_data_i,
  // Read side
  input  wire [7:0] rd_idx_i,
  output wire [7:0] rd_data_o,
  output wire       rd_valid_o
);
  reg [7:0]   mem [0:255];
  reg [255:0] valid;

  assign rd_data_o  = mem[rd_idx_i];
  assign rd_valid_o = valid[rd_idx_i];

  // Later bytes to the same slot overwrite earlier ones
  always @(posedge clk_i) begin
    if (reset_i) begin
      valid <= 256'h0;
    end else if (ce_i) begin
      if (clr_i) begin
        valid <= 256'h0;
      end else if (wr_i) begin
        valid[wr_idx_i] <= 1'b1;
      end
    end
  end

  always @(posedge clk_i) begin
    if (ce_i && wr_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end
endmodule

// file: sfep_sync.v
`timescale 1ns/1ps
module sfep_sync #(
  parameter WIDTH = 6
) (
  // Clocking
  input  wire             clk_i,
  input  wire             reset_i,
  input  wire             ce_i,
  // Data
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta;

  // Two-stage synchroniser, idle high
  always @(posedge clk_i) begin
    if (reset_i) begin
      meta   <= {WIDTH{1'b1}};
      sync_o <= {WIDTH{1'b1}};
    end else if (ce_i) begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk_i   = 1'b0;
  logic        reset_i = 1'b1;
  logic        ce_i    = 1'b1;
  logic [4:0]  bp      = 5'h00;
  logic        quad_en = 1'b0;
  logic        clr     = 1'b0;
  wire         cs_n, sclk, busy, latch, rej, eb, ec, pwe;
  wire  [3:0]  io;
  wire  [23:0] ea, pa;
  wire  [7:0]  pd;
  int          mismatches = 0;
  int          checks_done = 0;
  int          nrej, neb, nec;
  logic [23:0] lea;
  logic [31:0] pw[$];
  logic [7:0]  ceo[2] = '{8'hc7, 8'h60};

  always #2.5 clk_i = ~clk_i;

  sfep_host host (.cs_n_o(cs_n), .sclk_o(sclk), .io_o(io));

  sfep_core #(
    .BLOCK_ERASE_CYCLES(32'hc8),
    .CHIP_ERASE_CYCLES (32'h1e),
    .PAGE_PROG_CYCLES  (32'ha)
  ) dut (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .chip_select_n_i(cs_n), .serial_clock_i(sclk),
    .io_line_0_i(io[0]), .io_line_1_i(io[1]), .io_line_2_i(io[2]), .io_line_3_i(io[3]),
    .block_protect_bits_i(bp), .quad_enable_i(quad_en),
    .write_in_progress_o(busy), .write_enable_latch_o(latch), .cmd_reject_o(rej),
    .erase_block_o(eb), .erase_chip_o(ec), .erase_addr_o(ea),
    .prog_we_o(pwe), .prog_addr_o(pa), .prog_data_o(pd)
  );

  // Event monitor, the only writer of the event counters
  always @(posedge clk_i) begin
    if (clr) begin
      nrej = 0;
      neb  = 0;
      nec  = 0;
      pw.delete();
    end else begin
      if (rej)
        nrej++;
      if (ec)
        nec++;
      if (eb) begin
        neb++;
        lea = ea;
      end
      if (pwe)
        pw.push_back({pa, pd});
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc();
    @(posedge clk_i);
    #1;
  endtask

  task automatic setc(input logic [4:0] b, input logic q);
    cyc();
    bp = b;
    quad_en = q;
  endtask

  // One frame, an optional write enable while busy, then wait for idle
  task automatic run(input logic [7:0] op, input logic [23:0] a,
                     input int na, nd, w, xb, bz);
    cyc();
    clr = 1'b1;
    cyc();
    clr = 1'b0;
    host.frame(op, a, na, nd, w, xb, 8'h3c);
    if (bz != 0)
      host.frame(8'h06, 24'h0, 0, 0, 1, 0, 8'h00);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++)
      cyc();
  endtask

  task automatic wr_en();
    run(8'h06, 24'h0, 0, 0, 1, 0, 0);
    chk(latch, 1'b1);
  endtask

  // Expected page writes in ascending index order, later bytes win
  task automatic pchk(input logic [23:0] a, input int nd);
    logic [8:0] e[256];
    int j;
    j = 0;
    foreach (e[i])
      e[i] = 9'h000;
    for (int k = 0; k < nd; k++)
      e[(a[7:0] + k) % 256] = {1'b1, k[8:1] ^ 8'h3c};
    for (int i = 0; i < 256; i++)
      if (e[i][8]) begin
        chk(pw[j], {a[23:8], i[7:0], e[i][7:0]});
        j++;
      end
    chk(pw.size(), j);
  endtask

  task automatic prog(input logic [7:0] op, input logic [23:0] a, input int nd, w);
    wr_en();
    run(op, a, 3, nd, w, 0, 0);
    pchk(a, nd);
    chk(nrej, 0);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    #1 reset_i = 1'b0;
    repeat (4) cyc();
    chk({busy, latch, rej}, 3'h0);
    ce_i = 1'b0;
    run(8'h06, 24'h0, 0, 0, 1, 0, 0);
    cyc();
    ce_i = 1'b1;
    chk(latch, 1'b0);
    run(8'hd8, 24'h034567, 3, 0, 1, 0, 0);
    chk(nrej, 1);
    chk(neb, 0);
    wr_en();
    run(8'hd8, 24'h034567, 3, 0, 1, 0, 0);
    chk(neb, 1);
    chk(lea, 24'h030000);
    chk(latch, 1'b0);
    wr_en();
    run(8'hd8, 24'h034567, 3, 0, 1, 1, 0);
    chk(nrej, 1);
    chk(neb, 0);
    setc(5'h01, 1'b0);
    run(8'hc7, 24'h0, 0, 0, 1, 0, 0);
    chk(nec, 0);
    chk(latch, 1'b0);
    wr_en();
    run(8'hd8, 24'h07ffff, 3, 0, 1, 0, 0);
    chk(nrej, 1);
    chk(neb, 0);
    wr_en();
    run(8'hd8, 24'h00abcd, 3, 0, 1, 0, 0);
    chk(lea, 24'h000000);
    wr_en();
    run(8'h02, 24'h071000, 3, 1, 1, 0, 0);
    chk(pw.size(), 0);
    chk(latch, 1'b0);
    setc(5'h00, 1'b0);
    wr_en();
    run(8'hc7, 24'h0, 0, 0, 1, 3, 0);
    chk(nrej, 1);
    foreach (ceo[i]) begin
      wr_en();
      run(ceo[i], 24'h0, 0, 0, 1, 0, 0);
      chk(nec, 1);
    end
    prog(8'h02, 24'h0012fe, 3, 1);
    prog(8'h02, 24'h000500, 258, 1);
    prog(8'ha2, 24'h0201f0, 20, 2);
    setc(5'h00, 1'b1);
    prog(8'h32, 24'h0033fd, 5, 4);
    setc(5'h00, 1'b0);
    wr_en();
    run(8'h32, 24'h0033fd, 3, 4, 4, 0, 0);
    chk(nrej, 1);
    chk(pw.size(), 0);
    wr_en();
    run(8'h02, 24'h000100, 3, 2, 1, 4, 0);
    chk(nrej, 1);
    chk(pw.size(), 0);
    wr_en();
    run(8'hd8, 24'h010000, 3, 0, 1, 0, 1);
    chk(nrej, 1);
    chk(latch, 1'b0);
    wrap_up();
  end

  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end
endmodule
